// *** rtl/ocs_pkg.sv ***
// shared constants and types for the one-time-programmable code store
package ocs_pkg;

  // ********************************************************************
  // array geometry
  // ********************************************************************
  localparam int unsigned CODE_AW_DEF = 14;      // 16 Kbyte variant
  localparam int unsigned KEY_AW      = 6;       // 64 encryption bytes
  localparam int unsigned KEY_DEPTH   = 64;
  localparam int unsigned SIG_DEPTH   = 4;       // fixed signature bytes
  localparam int unsigned PIN_AW      = 16;      // address pins
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;   // unprogrammed cell value

  // ********************************************************************
  // programming pin modes (control combination)
  // ********************************************************************
  localparam logic [2:0] MODE_IDLE     = 3'h0;   // normal operation
  localparam logic [2:0] MODE_PROG     = 3'h1;   // program code byte
  localparam logic [2:0] MODE_VERIFY   = 3'h2;   // encrypted code verify
  localparam logic [2:0] MODE_PROG_KEY = 3'h3;   // program encryption byte
  localparam logic [2:0] MODE_LOCK1    = 3'h4;   // program first lock bit
  localparam logic [2:0] MODE_LOCK2    = 3'h5;   // program second lock bit
  localparam logic [2:0] MODE_LOCK3    = 3'h6;   // program third lock bit
  localparam logic [2:0] MODE_SIG      = 3'h7;   // read signature bytes

  // ********************************************************************
  // security levels, coded as level minus one
  // ********************************************************************
  localparam logic [1:0] LVL_1 = 2'h0;
  localparam logic [1:0] LVL_2 = 2'h1;
  localparam logic [1:0] LVL_3 = 2'h2;
  localparam logic [1:0] LVL_4 = 2'h3;

  // ********************************************************************
  // register map (byte addresses) and fields
  // ********************************************************************
  localparam logic [7:0] REG_CTRL     = 8'h00;   // erase command
  localparam logic [7:0] REG_STATUS   = 8'h04;   // lock, level, busy
  localparam logic [7:0] REG_TRD_ADDR = 8'h08;   // table read address
  localparam logic [7:0] REG_TRD_DATA = 8'h0C;   // table read data
  localparam logic [7:0] REG_PROG_CNT = 8'h10;   // accepted pulses
  localparam logic [7:0] REG_REFUSED  = 8'h14;   // refused pulses
  localparam int unsigned CTRL_ERASE  = 0;
  localparam int unsigned ST_LVL_LSB  = 4;
  localparam int unsigned ST_BUSY     = 8;
  localparam int unsigned ST_EA       = 9;
  localparam int unsigned TRD_EXT     = 31;      // read runs from external
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ********************************************************************
  // controller states
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_ERASE = 2'b01,                            // sweep arrays to ones
    ST_IDLE  = 2'b10                             // serve pins and bus
  } ocs_state_t;

endpackage

// *** rtl/ocs_guard_if.sv ***
// carrier between the store and its security guard
`timescale 1ns/1ps
interface ocs_guard_if;
  logic [2:0] lock;        // programmed lock bits, bit0 = first
  logic [7:0] code_byte;   // addressed code byte
  logic [7:0] key_byte;    // addressed encryption byte
  logic [1:0] level;       // security level minus one
  logic       verify_ok;   // verify path open
  logic       prog_ok;     // programming allowed
  logic       tbl_block;   // external table reads blocked
  logic       ext_exec_ok; // external execution allowed
  logic [7:0] enc_byte;    // encrypted verify byte
  modport store (output lock, code_byte, key_byte,
                 input level, verify_ok, prog_ok, tbl_block,
                 ext_exec_ok, enc_byte);
  modport guard (input lock, code_byte, key_byte,
                 output level, verify_ok, prog_ok, tbl_block,
                 ext_exec_ok, enc_byte);
endinterface

// *** rtl/ocs_sync.sv ***
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ocs_sync
  import ocs_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  // ********************************************************************
  // stage one feeds stage two only
  // ********************************************************************
  logic [W-1:0] meta_q;   // first stage

  // two flops per bit
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// *** rtl/ocs_guard.sv ***
// security level decode and verify encryption
`timescale 1ns/1ps
module ocs_guard
  import ocs_pkg::*;
(
  ocs_guard_if.guard g
);
  // ********************************************************************
  // highest programmed lock bit wins
  // ********************************************************************
  always_comb
  begin
    if (g.lock[2])
      g.level = LVL_4;
    else if (g.lock[1])
      g.level = LVL_3;
    else if (g.lock[0])
      g.level = LVL_2;
    else
      g.level = LVL_1;
  end

  // restrictions accumulate upward
  assign g.prog_ok     = (g.level == LVL_1);
  assign g.tbl_block   = (g.level != LVL_1);
  assign g.verify_ok   = (g.level == LVL_1) || (g.level == LVL_2);
  assign g.ext_exec_ok = (g.level != LVL_4);
  // verify output is always encrypted
  assign g.enc_byte    = ~(g.code_byte ^ g.key_byte);
endmodule

// *** rtl/ocs_store.sv ***
// one-time-programmable code store with lock bits and verify path
//
// Behaviour
// - code array plus 64-byte encryption array
// - fixed 4-byte signature array, never programmed
// - encryption bytes start erased, all ones
// - verify returns code XNOR key[addr low six]
// - level 1: no locks, verify still encrypted
// - level 2: block table reads, latch pin, no programming
// - level 3: level 2 plus verify disabled
// - level 4: level 3 plus no external execution
// - one program pulse programs one byte
// - port pin enables verify data output
// - no direct read of encryption array
// - erase returns all cells to ones and clears the locks
`timescale 1ns/1ps
module ocs_store
  import ocs_pkg::*;
#(
  parameter int unsigned CODE_AW = CODE_AW_DEF,  // 14: 16K, 15: 32K
  parameter logic [7:0]  SIG0    = 8'h11,        // arbitrary value
  parameter logic [7:0]  SIG1    = 8'h22,        // arbitrary value
  parameter logic [7:0]  SIG2    = 8'h33,        // arbitrary value
  parameter logic [7:0]  SIG3    = 8'h44         // arbitrary value
)(
  input  wire logic              CLK,
  input  wire logic              RST_B,
  // programmer pins
  input  wire logic [PIN_AW-1:0] PGM_ADDR,
  input  wire logic [7:0]        PGM_DATA_IN,
  output logic      [7:0]        PGM_DATA_OUT,
  output logic                   PGM_DATA_OE_B,
  input  wire logic [2:0]        PGM_MODE,
  input  wire logic              EXT_ACCESS_PROG_VOLTAGE_PIN,
  input  wire logic              ADDR_LATCH_PROG_STROBE_PIN_B,
  input  wire logic              VERIFY_EN_B,
  // core side
  output logic                   TBL_RD_BLOCK,
  output logic                   EXT_EXEC_EN,
  output logic                   EXT_ACCESS_LATCHED,
  // AXI4-Lite slave
  input  wire logic [7:0]        AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic      [1:0]        BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [7:0]        ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic      [31:0]       RDATA,
  output logic      [1:0]        RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);
  // ********************************************************************
  // storage
  // ********************************************************************
  localparam int unsigned CODE_DEPTH = 1 << CODE_AW;

  logic [7:0] code_mem [CODE_DEPTH];   // code array, no reset

  // all flopped state of the controller
  typedef struct packed {
    ocs_state_t             state;
    logic [CODE_AW-1:0]     ers_addr;  // erase sweep pointer
    logic [KEY_DEPTH*8-1:0] key;       // encryption array
    logic [2:0]             lock;      // 1 = programmed
    logic                   mem_we;    // code write strobe
    logic                   mem_ers;   // write is an erase
    logic [CODE_AW-1:0]     mem_wa;
    logic [7:0]             mem_wd;
    logic                   strobe_d1; // strobe pin last cycle
    logic                   ea_held;   // pin caught after reset
    logic                   ea_val;
    logic [7:0]             dout;
    logic                   oe_b;
    logic                   tbl_block;
    logic                   ext_en;
    logic                   ea_out;
    logic [CODE_AW-1:0]     trd_addr;
    logic                   trd_ext;
    logic [7:0]             trd_data;
    logic [15:0]            prog_cnt;
    logic [15:0]            ref_cnt;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             aw_addr;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } ocs_reg_t;

  ocs_reg_t r_q;   // registered state
  ocs_reg_t r_d;   // next state

  // ********************************************************************
  // pin synchronisers
  // ********************************************************************
  logic [PIN_AW-1:0] addr_s;
  logic [7:0]        din_s;
  logic [2:0]        mode_s;
  logic              vpp_s;
  logic              strobe_b_s;
  logic              ven_b_s;

  // data-carrying pins
  ocs_sync #(.W(PIN_AW + 11)) u_sync_bus
  (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   ({PGM_ADDR, PGM_DATA_IN, PGM_MODE}),
    .dout  ({addr_s, din_s, mode_s})
  );

  // control pins
  ocs_sync #(.W(3)) u_sync_ctl
  (
    .clk   (CLK),
    .rst_b (RST_B),
    .din   ({EXT_ACCESS_PROG_VOLTAGE_PIN, ADDR_LATCH_PROG_STROBE_PIN_B,
             VERIFY_EN_B}),
    .dout  ({vpp_s, strobe_b_s, ven_b_s})
  );

  // ********************************************************************
  // security guard
  // ********************************************************************
  ocs_guard_if gif ();

  logic [KEY_AW-1:0] key_idx;   // low six address bits
  assign key_idx       = addr_s[KEY_AW-1:0];
  assign gif.lock      = r_q.lock;
  assign gif.code_byte = code_mem[addr_s[CODE_AW-1:0]];
  assign gif.key_byte  = r_q.key[key_idx*8 +: 8];

  ocs_guard u_guard
  (
    .g (gif.guard)
  );

  // ********************************************************************
  // helpers
  // ********************************************************************
  // merge write data under byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
        m[i*8 +: 8] = wd[i*8 +: 8];
    end
    return m;
  endfunction

  // pick a fixed signature byte
  function automatic logic [7:0] sig_byte(input logic [1:0] idx);
    case (idx)
      2'h0:    return SIG0;
      2'h1:    return SIG1;
      2'h2:    return SIG2;
      default: return SIG3;
    endcase
  endfunction

  // status word for software
  logic [31:0] status_w;
  assign status_w = {22'h0, r_q.ea_out, (r_q.state == ST_ERASE),
                     2'h0, gif.level, 1'b0, r_q.lock};

  // table read address word merged under write strobes
  logic [31:0] trd_merged;
  assign trd_merged = merge_strb({r_q.trd_ext, 31'(r_q.trd_addr)},
                                 r_q.wdata, r_q.wstrb);

  logic prog_pulse;   // falling edge of synced strobe
  assign prog_pulse = r_q.strobe_d1 & ~strobe_b_s;

  logic prog_mode;    // any mode that programs a cell
  assign prog_mode = (mode_s == MODE_PROG) || (mode_s == MODE_PROG_KEY) ||
                     (mode_s == MODE_LOCK1) || (mode_s == MODE_LOCK2) ||
                     (mode_s == MODE_LOCK3);

  // ********************************************************************
  // next-state logic
  // ********************************************************************
  always_comb
  begin
    r_d           = r_q;
    r_d.mem_we    = 1'b0;
    r_d.mem_ers   = 1'b0;
    r_d.strobe_d1 = strobe_b_s;

    // controller sequence
    case (r_q.state)
      ST_ERASE:
      begin
        // sweep code array and key back to ones, clear locks to zero
        r_d.mem_we   = 1'b1;
        r_d.mem_ers  = 1'b1;
        r_d.mem_wa   = r_q.ers_addr;
        r_d.key      = '1;
        r_d.lock     = 3'h0;
        r_d.ers_addr = r_q.ers_addr + 1'b1;
        if (r_q.ers_addr == CODE_AW'(CODE_DEPTH - 1))
          r_d.state = ST_IDLE;
      end
      ST_IDLE:
      begin
        // one strobe pulse at program voltage programs one cell
        if (prog_pulse && vpp_s && prog_mode)
        begin
          if (gif.prog_ok)
          begin
            r_d.prog_cnt = r_q.prog_cnt + 1'b1;
            case (mode_s)
              MODE_PROG:
              begin
                r_d.mem_we = 1'b1;
                r_d.mem_wa = addr_s[CODE_AW-1:0];
                r_d.mem_wd = din_s;
              end
              MODE_PROG_KEY:
                r_d.key[key_idx*8 +: 8] = r_q.key[key_idx*8 +: 8] & din_s;
              MODE_LOCK1: r_d.lock[0] = 1'b1;
              MODE_LOCK2: r_d.lock[1] = 1'b1;
              MODE_LOCK3: r_d.lock[2] = 1'b1;
              default:    r_d.prog_cnt = r_q.prog_cnt;
            endcase
          end
          else
            r_d.ref_cnt = r_q.ref_cnt + 1'b1;
        end
      end
      default: r_d.state = ST_ERASE;
    endcase

    // verify and signature output to the data pins
    r_d.oe_b = 1'b1;
    r_d.dout = 8'h00;
    if (!ven_b_s && r_q.state == ST_IDLE)
    begin
      if (mode_s == MODE_VERIFY && gif.verify_ok)
      begin
        r_d.oe_b = 1'b0;
        r_d.dout = gif.enc_byte;
      end
      else if (mode_s == MODE_SIG)
      begin
        r_d.oe_b = 1'b0;
        r_d.dout = sig_byte({addr_s[6], addr_s[0]});
      end
    end

    // core-side restrictions
    r_d.tbl_block = gif.tbl_block;
    r_d.ext_en    = gif.ext_exec_ok;
    // wait for the sweep so the synchronisers hold the real pin level
    if (!r_q.ea_held && r_q.state == ST_IDLE)
    begin
      r_d.ea_held = 1'b1;
      r_d.ea_val  = vpp_s;
    end
    // locked parts use the value caught after reset
    r_d.ea_out = gif.tbl_block ? r_q.ea_val : vpp_s;

    // table read: no code from external when locked
    if (r_q.trd_ext && gif.tbl_block)
      r_d.trd_data = ERASED_BYTE;
    else
      r_d.trd_data = code_mem[r_q.trd_addr];

    // ---------------- AXI write channel ----------------
    if (AWVALID && r_q.awready)
    begin
      r_d.aw_got  = 1'b1;
      r_d.aw_addr = AWADDR;
    end
    if (WVALID && r_q.wready)
    begin
      r_d.w_got = 1'b1;
      r_d.wdata = WDATA;
      r_d.wstrb = WSTRB;
    end
    if (r_q.bvalid && BREADY)
      r_d.bvalid = 1'b0;
    if (r_q.aw_got && r_q.w_got && !r_q.bvalid)
    begin
      r_d.aw_got = 1'b0;
      r_d.w_got  = 1'b0;
      r_d.bvalid = 1'b1;
      r_d.bresp  = RESP_OKAY;
      case ({r_q.aw_addr[7:2], 2'b00})
        REG_CTRL:
        begin
          // erase restarts the sweep
          if (r_q.wstrb[0] && r_q.wdata[CTRL_ERASE])
          begin
            r_d.state    = ST_ERASE;
            r_d.ers_addr = '0;
          end
        end
        REG_TRD_ADDR:
        begin
          r_d.trd_ext  = trd_merged[TRD_EXT];
          r_d.trd_addr = trd_merged[CODE_AW-1:0];
        end
        REG_STATUS, REG_TRD_DATA, REG_PROG_CNT, REG_REFUSED: ;
        default: r_d.bresp = RESP_SLVERR;
      endcase
    end
    r_d.awready = ~r_d.aw_got & ~r_d.bvalid;
    r_d.wready  = ~r_d.w_got & ~r_d.bvalid;

    // ---------------- AXI read channel ----------------
    if (r_q.rvalid && RREADY)
      r_d.rvalid = 1'b0;
    if (ARVALID && r_q.arready)
    begin
      r_d.rvalid = 1'b1;
      r_d.rresp  = RESP_OKAY;
      r_d.rdata  = 32'h0;
      // no register exposes the encryption array
      case ({ARADDR[7:2], 2'b00})
        REG_CTRL:     r_d.rdata = 32'h0;
        REG_STATUS:   r_d.rdata = status_w;
        REG_TRD_ADDR: r_d.rdata = {r_q.trd_ext, 31'(r_q.trd_addr)};
        REG_TRD_DATA: r_d.rdata = {24'h0, r_q.trd_data};
        REG_PROG_CNT: r_d.rdata = {16'h0, r_q.prog_cnt};
        REG_REFUSED:  r_d.rdata = {16'h0, r_q.ref_cnt};
        default:      r_d.rresp = RESP_SLVERR;
      endcase
    end
    r_d.arready = ~r_d.rvalid;
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      r_q         <= '0;
      r_q.state   <= ST_ERASE;
      r_q.key     <= '1;
      r_q.oe_b    <= 1'b1;
      r_q.ext_en  <= 1'b1;
      r_q.strobe_d1 <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  // code array write port: program only clears bits, erase sets all
  always_ff @(posedge CLK)
  begin
    if (r_q.mem_we)
    begin
      if (r_q.mem_ers)
        code_mem[r_q.mem_wa] <= ERASED_BYTE;
      else
        code_mem[r_q.mem_wa] <= code_mem[r_q.mem_wa] & r_q.mem_wd;
    end
  end

  // ********************************************************************
  // outputs straight from flops
  // ********************************************************************
  assign PGM_DATA_OUT       = r_q.dout;
  assign PGM_DATA_OE_B      = r_q.oe_b;
  assign TBL_RD_BLOCK       = r_q.tbl_block;
  assign EXT_EXEC_EN        = r_q.ext_en;
  assign EXT_ACCESS_LATCHED = r_q.ea_out;
  assign AWREADY            = r_q.awready;
  assign WREADY             = r_q.wready;
  assign BRESP              = r_q.bresp;
  assign BVALID             = r_q.bvalid;
  assign ARREADY            = r_q.arready;
  assign RDATA              = r_q.rdata;
  assign RRESP              = r_q.rresp;
  assign RVALID             = r_q.rvalid;
endmodule

// *** test/ocs_store_asserts.sv ***
// port assertions for the code store
`timescale 1ns/1ps
module ocs_store_asserts
  import ocs_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic [2:0]  PGM_MODE,
  input wire logic        VERIFY_EN_B,
  input wire logic        PGM_DATA_OE_B,
  input wire logic        TBL_RD_BLOCK,
  input wire logic        EXT_EXEC_EN,
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_oe_enable: assert property (VERIFY_EN_B [*5] |=> PGM_DATA_OE_B)
    else $error("data driven without enable");
  a_oe_mode: assert property ((PGM_MODE != MODE_VERIFY
    && PGM_MODE != MODE_SIG) [*5] |=> PGM_DATA_OE_B)
    else $error("data driven outside read modes");
  a_exec_block: assert property (!EXT_EXEC_EN |-> TBL_RD_BLOCK)
    else $error("exec off without table block");
  a_bvalid_hold: assert property (BVALID && !BREADY |=>
    BVALID && $stable(BRESP)) else $error("write answer dropped");
  a_rvalid_hold: assert property (RVALID && !RREADY |=>
    RVALID && $stable(RDATA)) else $error("read answer dropped");
  a_read_lat: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  a_write_lat: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##2 BVALID) else $error("write answer late");
  a_ar_refused: assert property (RVALID |-> !ARREADY)
    else $error("address taken while answering");
  c_verify: cover property (!PGM_DATA_OE_B);
  c_block: cover property (TBL_RD_BLOCK);
  c_noexec: cover property (!EXT_EXEC_EN);
endmodule
bind ocs_store ocs_store_asserts u_chk (.CLK(CLK), .RST_B(RST_B),
  .PGM_MODE(PGM_MODE), .VERIFY_EN_B(VERIFY_EN_B), .RDATA(RDATA),
  .PGM_DATA_OE_B(PGM_DATA_OE_B), .TBL_RD_BLOCK(TBL_RD_BLOCK),
  .EXT_EXEC_EN(EXT_EXEC_EN), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
  .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
  .RVALID(RVALID), .RREADY(RREADY));

// *** test/ocs_prog_model.sv ***
// external programmer driving the store's pins
`timescale 1ns/1ps
module ocs_prog_model
  import ocs_pkg::*;
(
  input wire logic  clk,
  output logic [15:0] addr,
  output logic [7:0]  din,
  output logic [2:0]  mode,
  output logic        hv,
  output logic        strobe_b,
  output logic        ven_b,
  input wire logic [7:0] dout,
  input wire logic  oe_b
);
  initial
  begin
    {addr, din, mode, hv, strobe_b, ven_b} = {16'h0, 8'hFF, 3'h0, 3'h3};
  end
  // one byte: mode, address, data, voltage, single pulse
  task automatic prog(input logic [2:0] m, input logic [15:0] a,
                      input logic [7:0] d);
    mode <= m;
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    din <= d;
    @(posedge clk);
    hv <= 1'b1;
    repeat (4) @(posedge clk);
    strobe_b <= 1'b0;
    repeat (3) @(posedge clk);
    strobe_b <= 1'b1;
    repeat (6) @(posedge clk);
    hv <= 1'b0;
    din <= ~d;
    mode <= MODE_IDLE;
    @(posedge clk);
  endtask
  // read back; undriven line shows as 9'h100
  task automatic verify(input logic [2:0] m, input logic [15:0] a,
                        output logic [8:0] r);
    mode <= m;
    addr <= a;
    ven_b <= 1'b0;
    repeat (8) @(posedge clk);
    r = oe_b ? 9'h100 : {1'b0, dout};
    ven_b <= 1'b1;
    mode <= MODE_IDLE;
    repeat (6) @(posedge clk);
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the code store
`timescale 1ns/1ps
module testbench
  import ocs_pkg::*;
;
  localparam logic [7:0] SV [4] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4};
  localparam logic [15:0] SA [4] = '{16'h30, 16'h31, 16'h60, 16'h61};
  logic clk = 0, rst_b, hv, stb_b, ven_b, oe_b, tbl, exe, ea;
  logic [15:0] addr;
  logic [7:0] din, dout, awaddr, araddr;
  logic [2:0] mode;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, n;
  logic [8:0] v;
  int miscompares = 0, num_checks = 0;
  always #2 clk = ~clk;
  ocs_prog_model prog_i (.clk(clk), .addr(addr), .din(din), .mode(mode),
    .hv(hv), .strobe_b(stb_b), .ven_b(ven_b), .dout(dout), .oe_b(oe_b));
  ocs_store #(.CODE_AW(7), .SIG0(SV[0]), .SIG1(SV[1]), .SIG2(SV[2]),
    .SIG3(SV[3])) DUT (.CLK(clk), .RST_B(rst_b), .PGM_ADDR(addr),
    .PGM_DATA_IN(din), .PGM_DATA_OUT(dout), .PGM_DATA_OE_B(oe_b),
    .PGM_MODE(mode), .EXT_ACCESS_PROG_VOLTAGE_PIN(hv),
    .ADDR_LATCH_PROG_STROBE_PIN_B(stb_b), .VERIFY_EN_B(ven_b),
    .TBL_RD_BLOCK(tbl), .EXT_EXEC_EN(exe), .EXT_ACCESS_LATCHED(ea),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  task automatic chk(input string s, input logic [31:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic settle;
    do axr(REG_STATUS, rd); while (rd[ST_BUSY] !== 1'b0);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    rst_b = 0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready} = '0;
    repeat (4) @(posedge clk);
    chk("oe", oe_b, 1'b1);
    chk("exec", {tbl, exe}, 2'b01);
    rst_b <= 1'b1;
    settle;
    chk("status", rd[5:0], 6'h0);
    prog_i.prog(MODE_PROG, 16'h30, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      prog_i.verify(MODE_SIG, SA[i], v);
      chk("sig", v, {1'b0, SV[i]});
    end
    prog_i.verify(MODE_VERIFY, 16'h30, v);
    chk("plain", v, 9'h000);
    prog_i.prog(MODE_PROG, 16'h5, 8'hA5);
    prog_i.prog(MODE_PROG_KEY, 16'h5, 8'h0F);
    prog_i.verify(MODE_VERIFY, 16'h5, v);
    chk("xnor", v, 9'h055);
    prog_i.verify(MODE_VERIFY, 16'h45, v);
    chk("keyleak", v, 9'h00F);
    axr(REG_PROG_CNT, rd);
    chk("pulses", rd[15:0], 16'h3);
    axw(REG_TRD_ADDR, 32'h80000005);
    axr(REG_TRD_ADDR, rd);
    chk("trd_addr", rd, 32'h80000005);
    axr(REG_TRD_DATA, rd);
    chk("table", rd, 32'h000000A5);
    axr(8'h40, rd);
    chk("unmapped", rd, 32'h0);
    chk("rresp", rresp, RESP_SLVERR);
    for (int lv = 1; lv < 4; lv++)
    begin
      prog_i.prog(MODE_LOCK1 + 3'(lv - 1), 16'h0, 8'h0);
      axr(REG_STATUS, rd);
      chk("level", rd[5:0], {2'(lv), 1'b0, 3'(1 << (lv - 1))});
      chk("lock", {tbl, exe, ea}, {1'b1, lv != 3, 1'b0});
      axr(REG_TRD_DATA, rd);
      chk("tblrd", rd, 32'h000000FF);
      axr(REG_REFUSED, n);
      prog_i.prog(MODE_PROG, 16'h5, 8'h00);
      axr(REG_REFUSED, rd);
      chk("refused", rd[15:0], n[15:0] + 16'h1);
      prog_i.verify(MODE_VERIFY, 16'h5, v);
      chk("locked", v, lv == 1 ? 9'h055 : 9'h100);
      axw(REG_CTRL, 32'h1);
      settle;
      chk("erase", {rd[5:0], tbl, exe}, 8'h01);
    end
    prog_i.verify(MODE_VERIFY, 16'h5, v);
    chk("blank", v, 9'h0FF);
    end_of_test;
  end
endmodule
